//--- hdl/mpgc_ahb_slave.sv
// ahb-lite slave front end for the gpio registers
// assumes single word transfers; read data captured in the address phase, or one cycle later behind a write
`timescale 1ns/10ps
`default_nettype none
`include "mpgc_regs.svh"
module mpgc_ahb_slave (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  mpgc_bus_if.slave        bus
);
  mpgc_pkg::mpgc_state_t state_reg;
  mpgc_pkg::mpgc_state_t state_next;
  mpgc_pkg::mpgc_idx_t   idx_reg;
  logic                  ok_reg;
  logic                  accept;
  logic                  addr_ok;
  logic                  rd_now;
  logic [31:0]           rd_word;

  assign accept  = hsel & htrans[1] & hready;
  assign addr_ok = (haddr[31:7] == 25'h0) & (haddr[1:0] == 2'b00) & (hsize == 3'b010);
  // a read behind a write waits one cycle so it sees the fresh value
  assign rd_now  = accept & ~hwrite & (state_reg != mpgc_pkg::MPGC_ST_WRITE);
  assign bus.rd_idx  = (state_reg == mpgc_pkg::MPGC_ST_LATE) ? idx_reg : haddr[6:2];
  assign bus.wr_en   = (state_reg == mpgc_pkg::MPGC_ST_WRITE) & ok_reg;
  assign bus.wr_idx  = idx_reg;
  assign bus.wr_data = hwdata[7:0];
  assign rd_word     = {24'h00_0000, bus.rd_hit ? bus.rd_data : 8'h00};

  always_comb begin
    state_next = mpgc_pkg::MPGC_ST_IDLE;
    if (accept & hwrite) begin
      state_next = mpgc_pkg::MPGC_ST_WRITE;
    end else if (accept & (state_reg == mpgc_pkg::MPGC_ST_WRITE)) begin
      state_next = mpgc_pkg::MPGC_ST_LATE;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= mpgc_pkg::MPGC_ST_IDLE;
      idx_reg   <= 5'h00;
      ok_reg    <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      state_reg <= state_next;
      hresp     <= 1'b0;
      if (accept) begin
        idx_reg <= haddr[6:2];
        ok_reg  <= addr_ok;
      end
      if (rd_now) begin
        hrdata <= addr_ok ? rd_word : 32'h0000_0000;
      end else if (state_reg == mpgc_pkg::MPGC_ST_LATE) begin
        hrdata <= ok_reg ? rd_word : 32'h0000_0000;
      end
      hreadyout <= (state_next != mpgc_pkg::MPGC_ST_LATE);
    end
  end
endmodule
`default_nettype wire

//--- hdl/mpgc_bus_if.sv
// register access channel between bus slave and register file
// assumes both ends on mclk
`timescale 1ns/10ps
`default_nettype none
interface mpgc_bus_if;
  logic               wr_en;
  mpgc_pkg::mpgc_idx_t  wr_idx;
  mpgc_pkg::mpgc_byte_t wr_data;
  mpgc_pkg::mpgc_idx_t  rd_idx;
  mpgc_pkg::mpgc_byte_t rd_data;
  logic               rd_hit;
  modport slave (output wr_en, wr_idx, wr_data, rd_idx, input rd_data, rd_hit);
  modport regs  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data, rd_hit);
endinterface
`default_nettype wire

//--- hdl/mpgc_pin_sync.sv
// three-stage synchroniser with agreement filter for pin levels
// assumes asynchronous inputs; output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module mpgc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;
  logic [W-1:0] sync_next;

  assign agree     = ~(s2_reg ^ s3_reg);
  assign sync_next = (agree & s3_reg) | (~agree & sync_out);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      sync_out <= '0;
    end else begin
      s1_reg   <= async_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sync_out <= sync_next;
    end
  end
endmodule
`default_nettype wire

//--- hdl/mpgc_pkg.sv
// types shared by the gpio port block
// assumes nothing beyond a systemverilog compiler
package mpgc_pkg;
  typedef logic [7:0] mpgc_byte_t;
  typedef logic [4:0] mpgc_idx_t;
  // ==========================================
  // bus slave states
  typedef enum logic [2:0] {
    MPGC_ST_IDLE  = 3'b001,
    MPGC_ST_WRITE = 3'b010,
    MPGC_ST_LATE  = 3'b100
  } mpgc_state_t;
endpackage

//--- hdl/mpgc_regs.svh
// register offsets, pin capability masks and reset values of the gpio port block
// assumes bit 8*p+b of every flat vector is pin b of port p (a=0 .. f=5)
//
// Contract
// - aux-supply pins grounded while supply absent
// - input with alternate output reads alternate value
// - output pin feeds latch level to alternate input
// - port b: 0 floating, 1 push-pull
// - port a option picks interrupt / push-pull
// - port c interrupt option, push-pull only
// - port d configured like port a
// - port e no interrupt, pe5 optional pull-up
// - port f true open-drain except 3:2
// - latch writes always stored, even as input
// - data read returns pin level
// - direction bit 0 input, 1 output
// - option 1 adds interrupt on a, c, d
// - output option 0 open-drain, 1 push-pull
// - no option register: direction alone decides
// - registers at indices 0..16, 5 unused, reset zero
// - true open-drain never drives high
// - any enabled low pin masks its group
// - request latch hidden, cleared on vector fetch
// - driving peripheral overrides and forces output
`ifndef MPGC_REGS_SVH
`define MPGC_REGS_SVH
// ==========================================
// register indices (byte address is four times the index)
`define MPGC_IDX_A_DATA 5'h00
`define MPGC_IDX_A_DIR  5'h01
`define MPGC_IDX_A_OPT  5'h02
`define MPGC_IDX_B_DATA 5'h03
`define MPGC_IDX_B_DIR  5'h04
`define MPGC_IDX_C_DATA 5'h06
`define MPGC_IDX_C_DIR  5'h07
`define MPGC_IDX_C_OPT  5'h08
`define MPGC_IDX_D_DATA 5'h09
`define MPGC_IDX_D_DIR  5'h0a
`define MPGC_IDX_D_OPT  5'h0b
`define MPGC_IDX_E_DATA 5'h0c
`define MPGC_IDX_E_DIR  5'h0d
`define MPGC_IDX_E_OPT  5'h0e
`define MPGC_IDX_F_DATA 5'h0f
`define MPGC_IDX_F_DIR  5'h10
`define MPGC_IDX_NONE   5'h1f
`define MPGC_REG_RESET  8'h00
// ==========================================
// per-pin capability masks
`define MPGC_HAS_OPT    48'h00ff_ffff_00ff
`define MPGC_INT_CAP    48'h0000_ffff_00ff
`define MPGC_PP_ONLY    48'h0c00_00ff_ff00
`define MPGC_TRUE_OD    48'h7300_0000_0000
`define MPGC_PRESENT    48'h7fff_ffff_ffff
`define MPGC_AUX_PINS   48'h00ff_0000_0000
`define MPGC_PE5_BIT    37
`endif

//--- hdl/mpgc_top.sv
// six-port gpio block: registers, pin drivers, alternate functions, interrupt groups
// assumes an ahb-lite master on mclk and external pads resolving out/oe_n
`timescale 1ns/10ps
`default_nettype none
`include "mpgc_regs.svh"
module mpgc_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic [47:0] pad_in,
  output var  logic [47:0] pad_out_reg,
  output var  logic [47:0] pad_oe_n_reg,
  input  wire logic        aux_io_supply,
  input  wire logic        nv_pullup_sel,
  output var  logic        pe5_pullup_reg,
  input  wire logic [47:0] alt_en,
  input  wire logic [47:0] alt_out_en,
  input  wire logic [47:0] alt_out,
  input  wire logic [47:0] alt_od,
  output var  logic [47:0] alt_in_reg,
  input  wire logic [5:0]  irq_sense,
  input  wire logic [2:0]  irq_ack,
  output var  logic [2:0]  irq_req_reg
);
  localparam logic [47:0] HAS_OPT = `MPGC_HAS_OPT;
  localparam logic [47:0] INT_CAP = `MPGC_INT_CAP;
  localparam logic [47:0] PP_ONLY = `MPGC_PP_ONLY;
  localparam logic [47:0] TRUE_OD = `MPGC_TRUE_OD;
  localparam logic [47:0] PRESENT = `MPGC_PRESENT;
  localparam logic [47:0] AUX     = `MPGC_AUX_PINS;
  localparam mpgc_pkg::mpgc_idx_t DATA_IDX [6] = '{`MPGC_IDX_A_DATA, `MPGC_IDX_B_DATA,
    `MPGC_IDX_C_DATA, `MPGC_IDX_D_DATA, `MPGC_IDX_E_DATA, `MPGC_IDX_F_DATA};
  localparam mpgc_pkg::mpgc_idx_t DIR_IDX [6] = '{`MPGC_IDX_A_DIR, `MPGC_IDX_B_DIR,
    `MPGC_IDX_C_DIR, `MPGC_IDX_D_DIR, `MPGC_IDX_E_DIR, `MPGC_IDX_F_DIR};
  localparam mpgc_pkg::mpgc_idx_t OPT_IDX [6] = '{`MPGC_IDX_A_OPT, `MPGC_IDX_NONE,
    `MPGC_IDX_C_OPT, `MPGC_IDX_D_OPT, `MPGC_IDX_E_OPT, `MPGC_IDX_NONE};
  // interrupt groups: ei0 port a, ei1 port d, ei2 port c
  localparam int GRP_PORT [3] = '{0, 3, 2};

  mpgc_bus_if bus ();

  logic [47:0] latch_reg;
  logic [47:0] dir_reg;
  logic [47:0] opt_reg;
  logic [47:0] latch_next;
  logic [47:0] dir_next;
  logic [47:0] opt_next;
  logic [47:0] pin_s;
  logic        aux_ok;
  logic [47:0] alt_drv;
  logic [47:0] out_mode;
  logic [47:0] drv_val;
  logic [47:0] push_pull;
  logic [47:0] aux_kill;
  logic [47:0] rd_bit;
  logic [47:0] alt_in_next;
  logic [47:0] pad_out_next;
  logic [47:0] pad_oe_n_next;
  logic [47:0] int_en;
  logic [7:0]  rd_part [6];
  logic [5:0]  hit_part;
  logic [2:0]  grp_lvl;
  logic [2:0]  grp_prev_reg;
  logic [2:0]  grp_rise;
  logic [2:0]  grp_fall;
  logic [2:0]  grp_set;
  logic [2:0]  irq_req_next;
  logic        pe5_pullup_next;

  // ==========================================
  // bus front end and synchronisers
  mpgc_ahb_slave u_slave (
    .mclk      (mclk),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .bus       (bus.slave)
  );

  // pins are sampled before any read or edge detection
  mpgc_pin_sync #(.W(48)) u_pin_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (pad_in),
    .sync_out (pin_s)
  );

  // supply seen as absent until it has passed the filter after reset
  mpgc_pin_sync #(.W(1)) u_aux_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (aux_io_supply),
    .sync_out (aux_ok)
  );

  // ==========================================
  // register file, per port
  genvar p;
  genvar i;
  generate
    for (p = 0; p < 6; p++) begin : g_port
      logic wr_data_sel;
      logic wr_dir_sel;
      logic wr_opt_sel;
      logic rd_data_sel;
      logic rd_dir_sel;
      logic rd_opt_sel;
      // decode over indices 0..16 with 5 left open
      assign wr_data_sel = bus.wr_en & (bus.wr_idx == DATA_IDX[p]);
      assign wr_dir_sel  = bus.wr_en & (bus.wr_idx == DIR_IDX[p]);
      assign wr_opt_sel  = bus.wr_en & (bus.wr_idx == OPT_IDX[p]);
      assign rd_data_sel = (bus.rd_idx == DATA_IDX[p]);
      assign rd_dir_sel  = (bus.rd_idx == DIR_IDX[p]);
      assign rd_opt_sel  = (bus.rd_idx == OPT_IDX[p]) & (OPT_IDX[p] != `MPGC_IDX_NONE);
      // latch takes every write whatever the direction
      assign latch_next[8*p+:8] = wr_data_sel ? bus.wr_data : latch_reg[8*p+:8];
      assign dir_next[8*p+:8]   = wr_dir_sel ? bus.wr_data : dir_reg[8*p+:8];
      // ports without option register keep zero there unless index 1f is written
      assign opt_next[8*p+:8]   = wr_opt_sel ? bus.wr_data : opt_reg[8*p+:8];
      assign hit_part[p] = rd_data_sel | rd_dir_sel | rd_opt_sel;
      assign rd_part[p]  = ({8{rd_data_sel}} & rd_bit[8*p+:8])
                         | ({8{rd_dir_sel}} & dir_reg[8*p+:8])
                         | ({8{rd_opt_sel}} & opt_reg[8*p+:8]);
    end
  endgenerate

  always_comb begin
    bus.rd_data = 8'h00;
    for (int k = 0; k < 6; k++) begin
      bus.rd_data = bus.rd_data | rd_part[k];
    end
  end
  assign bus.rd_hit = |hit_part;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      latch_reg <= {6{`MPGC_REG_RESET}};
      dir_reg   <= {6{`MPGC_REG_RESET}};
      opt_reg   <= {6{`MPGC_REG_RESET}};
    end else begin
      latch_reg <= latch_next;
      dir_reg   <= dir_next;
      opt_reg   <= opt_next;
    end
  end

  // ==========================================
  // pin configuration, per pin
  generate
    for (i = 0; i < 48; i++) begin : g_pin
      // a driving peripheral overrides and forces output
      assign alt_drv[i]  = alt_en[i] & alt_out_en[i];
      // direction 1 output, 0 input
      assign out_mode[i] = alt_drv[i] | dir_reg[i];
      assign drv_val[i]  = alt_drv[i] ? alt_out[i] : latch_reg[i];
      // b, c and f3:2 fixed push-pull; option 1 push-pull, 0 open-drain
      // true open-drain never gets the high-side driver
      assign push_pull[i] = ~TRUE_OD[i] & (alt_drv[i] ? ~alt_od[i]
                          : (PP_ONLY[i] | (HAS_OPT[i] & opt_reg[i])));
      assign aux_kill[i]  = AUX[i] & ~aux_ok;
      // pin level read back; alternate output when configured input
      assign rd_bit[i] = (aux_kill[i] | ~PRESENT[i]) ? 1'b0
                       : (~dir_reg[i] & alt_drv[i]) ? alt_out[i] : pin_s[i];
      // alternate input sees the latch when the direction bit makes the pin an output and no peripheral drives it
      assign alt_in_next[i] = aux_kill[i] ? 1'b0
                            : (dir_reg[i] & ~alt_drv[i]) ? latch_reg[i] : pin_s[i];
      assign pad_out_next[i]  = ~aux_kill[i] & PRESENT[i] & drv_val[i];
      assign pad_oe_n_next[i] = aux_kill[i] ? 1'b0
                              : ~(PRESENT[i] & out_mode[i] & (push_pull[i] | ~drv_val[i]));
      // interrupt input only on a, c, d with option 1 as input
      assign int_en[i] = INT_CAP[i] & ~dir_reg[i] & opt_reg[i] & ~alt_drv[i];
    end
  endgenerate

  // pull-up only while the pin is not actively driven high or low by push-pull
  assign pe5_pullup_next = nv_pullup_sel & aux_ok
                         & ~(out_mode[`MPGC_PE5_BIT] & push_pull[`MPGC_PE5_BIT]);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pad_out_reg    <= 48'h0000_0000_0000;
      pad_oe_n_reg   <= ~`MPGC_AUX_PINS;
      alt_in_reg     <= 48'h0000_0000_0000;
      pe5_pullup_reg <= 1'b0;
    end else begin
      pad_out_reg    <= pad_out_next;
      pad_oe_n_reg   <= pad_oe_n_next;
      alt_in_reg     <= alt_in_next;
      pe5_pullup_reg <= pe5_pullup_next;
    end
  end

  // ==========================================
  // interrupt groups
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_grp
      logic [7:0] lvl_bits;
      logic [1:0] sense;
      // enabled pins are and-ed; a disabled group idles high
      assign lvl_bits    = pin_s[8*GRP_PORT[g]+:8] | ~int_en[8*GRP_PORT[g]+:8];
      assign grp_lvl[g]  = &lvl_bits;
      assign sense       = irq_sense[2*g+:2];
      assign grp_rise[g] = grp_lvl[g] & ~grp_prev_reg[g];
      assign grp_fall[g] = ~grp_lvl[g] & grp_prev_reg[g];
      assign grp_set[g]  = (sense == 2'b00) ? ~grp_lvl[g]
                         : (sense == 2'b01) ? grp_rise[g]
                         : (sense == 2'b10) ? grp_fall[g]
                         : (grp_rise[g] | grp_fall[g]);
      // hidden latch, vector fetch clears, a new event wins
      assign irq_req_next[g] = grp_set[g] | (irq_req_reg[g] & ~irq_ack[g]);
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      grp_prev_reg <= 3'b111;
      irq_req_reg  <= 3'b000;
    end else begin
      grp_prev_reg <= grp_lvl;
      irq_req_reg  <= irq_req_next;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_AUX_LOW: assert property (!aux_ok |=> ((pad_out_reg & AUX) == 48'h0
      && (pad_oe_n_reg & AUX) == 48'h0)) else $error("aux pins not grounded");
  AST_TRUE_OD: assert property ((pad_out_reg & ~pad_oe_n_reg & TRUE_OD) == 48'h0)
    else $error("true open-drain pin driven high");
  AST_LATCH_WR: assert property ((bus.wr_en && bus.wr_idx == `MPGC_IDX_A_DATA)
      |=> latch_reg[7:0] == $past(bus.wr_data)) else $error("latch write lost");
  AST_PB_PP: assert property ((dir_reg[8] && !alt_out_en[8])
      |=> (!pad_oe_n_reg[8] && pad_out_reg[8] == $past(latch_reg[8])))
    else $error("port b output not push-pull");
  AST_OPEN_DRAIN: assert property ((dir_reg[0] && !opt_reg[0] && latch_reg[0]
      && !alt_out_en[0]) |=> pad_oe_n_reg[0]) else $error("open-drain drove high");
  AST_DIR_IN: assert property ((!dir_reg[0] && !alt_out_en[0]) |=> pad_oe_n_reg[0])
    else $error("input pin driven");
  AST_ALT_IN: assert property ((dir_reg[0] && !alt_drv[0])
      |=> alt_in_reg[0] == $past(latch_reg[0])) else $error("alternate input not latch");
  AST_READ_PIN: assert property ((bus.rd_idx == `MPGC_IDX_A_DATA && !alt_drv[0])
      |-> bus.rd_data[0] == pin_s[0]) else $error("data read not pin level");
  AST_GRP_MASK: assert property ((int_en[0] && !pin_s[0]) |=> !grp_prev_reg[0])
    else $error("low pin did not mask group");
  AST_IRQ_ACK: assert property ((irq_ack[0] && !grp_set[0]) |=> !irq_req_reg[0])
    else $error("request not cleared by fetch");

  COV_WRITE_READ: cover property (bus.wr_en ##1 (bus.rd_idx == bus.wr_idx));
  COV_IRQ: cover property (grp_set[0] ##1 irq_req_reg[0] ##[1:4] irq_ack[0]);
  COV_AUX_UP: cover property (!aux_ok ##1 aux_ok);
endmodule
`default_nettype wire

//--- testbench/mpgc_bench.sv
// self-checking bench of the gpio port block against a register and pin model
// assumes the gpio top, its header and the board model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "mpgc_regs.svh"
module mpgc_bench;
  logic        mclk, reset, hsel, hwrite, aux_io_supply, nv_pullup_sel;
  logic        hreadyout, hresp, pe5_pullup_reg;
  logic [1:0]  htrans;
  logic [2:0]  hsize, irq_ack, irq_req_reg;
  logic [5:0]  irq_sense;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [47:0] pad_in, pad_out_reg, pad_oe_n_reg, alt_in_reg;
  logic [47:0] alt_en, alt_out_en, alt_out, alt_od;
  logic [47:0] ext_en, ext_val, mlat, mdir, mopt, drv, val, pin;
  int          miscompares, n_compared, cyc;

  mpgc_top i_mpgc_top (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pad_in(pad_in),
    .pad_out_reg(pad_out_reg), .pad_oe_n_reg(pad_oe_n_reg), .aux_io_supply(aux_io_supply),
    .nv_pullup_sel(nv_pullup_sel), .pe5_pullup_reg(pe5_pullup_reg), .alt_en(alt_en),
    .alt_out_en(alt_out_en), .alt_out(alt_out), .alt_od(alt_od), .alt_in_reg(alt_in_reg),
    .irq_sense(irq_sense), .irq_ack(irq_ack), .irq_req_reg(irq_req_reg));
  mpgc_pin_env i_mpgc_pin_env (.pad_out(pad_out_reg), .pad_oe_n(pad_oe_n_reg),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ==========================================
  // reporting
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t register read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t pin vector %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic [2:0] exp);
    n_compared++;
    if (irq_req_reg !== exp) begin
      miscompares++;
      $display("[ERR] %0t request latch %b expected %b", $time, irq_req_reg, exp);
    end
  endtask

  // ==========================================
  // ahb-lite single word transfers; byte address is four times the index
  task automatic ahb(input logic wr, input int idx, input logic [7:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= 32'(idx * 4);
    hsize  <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'ha5_5a3c, d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input int idx, input logic [7:0] d);
    ahb(1'b1, idx, d);
    case (idx % 3)
      0: mlat[8*(idx/3) +: 8] = d;
      1: mdir[8*(idx/3) +: 8] = d;
      default: mopt[8*(idx/3) +: 8] = d;
    endcase
  endtask

  // ==========================================
  // pin model: what the block drives and what each data read returns
  function automatic void model();
    logic [47:0] pp, aeo;
    pp  = mdir & ((mopt & `MPGC_HAS_OPT) | `MPGC_PP_ONLY);
    drv = pp | (mdir & ~mlat & `MPGC_PRESENT);
    val = pp & mlat;
    aeo = alt_en & alt_out_en;
    drv = drv | aeo;
    val = (val & ~aeo) | (alt_out & aeo);
    if (aux_io_supply !== 1'b1) begin
      drv = drv | `MPGC_AUX_PINS;
      val = val & ~`MPGC_AUX_PINS;
    end
    pin = ((drv & val) | (~drv & ~(ext_en & ~ext_val))) & `MPGC_PRESENT;
  endfunction
  task automatic check_all();
    logic pu;
    repeat (8) @(posedge mclk);
    model();
    pu = nv_pullup_sel & aux_io_supply & ~(mdir[37] & mopt[37]);
    chk_pin(pad_oe_n_reg, ~drv);
    chk_pin(pad_out_reg & drv, val & drv);
    chk_pin(alt_in_reg & alt_en & ~alt_out_en & mdir, mlat & alt_en & ~alt_out_en & mdir);
    chk_pin({47'h0000_0000_0000, pe5_pullup_reg}, {47'h0000_0000_0000, pu});
    for (int p = 0; p < 6; p++) begin
      ahb(1'b0, 3 * p, 8'h00);
      chk_rd(q, {24'h00_0000, pin[8*p +: 8]});
    end
  endtask

  // ==========================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 30000) begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    reset = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; hsize = 3'h2;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; aux_io_supply = 1'b0;
    nv_pullup_sel = 1'b1; irq_sense = 6'h2a; irq_ack = 3'h0; alt_en = 48'h0;
    alt_out_en = 48'h0; alt_out = 48'h0; alt_od = 48'h0; ext_en = 48'h0; ext_val = 48'h0;
    mlat = 48'h0; mdir = 48'h0; mopt = 48'h0; miscompares = 0; n_compared = 0; cyc = 0;
    void'($urandom(32'h1e04_704d));
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    check_all();
    for (int i = 1; i < 17; i++) begin
      if (i % 3 != 0) begin
        ahb(1'b0, i, 8'h00);
        chk_rd(q, 32'h0000_0000);
      end
    end
    aux_io_supply <= 1'b1;
    for (int it = 0; it < 12; it++) begin
      for (int p = 0; p < 6; p++) begin
        wr(3 * p, 8'($urandom));
        wr(3 * p + 1, 8'($urandom));
        if (p != 1 && p != 5) wr(3 * p + 2, 8'($urandom));
      end
      aux_io_supply <= (it % 4 != 3);
      model();
      ext_en        <= 48'({$urandom, $urandom}) & ~drv;
      ext_val       <= 48'({$urandom, $urandom});
      nv_pullup_sel <= 1'($urandom);
      check_all();
      for (int i = 1; i < 17; i++) begin
        if (i % 3 != 0 && i != 5) begin
          ahb(1'b0, i, 8'h00);
          chk_rd(q, {24'h00_0000, (i % 3 == 1) ? mdir[8*(i/3) +: 8] : mopt[8*(i/3) +: 8]});
        end
      end
    end
    aux_io_supply <= 1'b1;
    ext_en <= 48'h0;
    wr(0, 8'($urandom));
    wr(1, 8'hf0);
    alt_en     <= 48'h0000_0000_00ff;
    alt_out_en <= 48'h0000_0000_000f;
    alt_out    <= {16'h0000, $urandom};
    check_all();
    alt_en <= 48'h0;
    alt_out_en <= 48'h0;
    for (int p = 0; p < 5; p++) wr(3 * p + 1, 8'h00);
    for (int p = 0; p < 5; p++) if (p != 1) wr(3 * p + 2, 8'h00);
    repeat (8) @(posedge mclk);
    irq_ack <= 3'h7;
    @(posedge mclk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge mclk);
    chk_irq(3'h0);
    irq_sense <= 6'h15;
    wr(2, 8'h03);
    irq_sense <= 6'h2a;
    // board pulls pins 2:0 of port a low; leftover random levels would hide the fall
    ext_val <= 48'h0000_0000_0000;
    ext_en <= 48'h0000_0000_0007;
    repeat (8) @(posedge mclk);
    chk_irq(3'h1);
    irq_ack <= 3'h1;
    @(posedge mclk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge mclk);
    chk_irq(3'h0);
    ext_en <= 48'h0000_0000_0006;
    repeat (8) @(posedge mclk);
    ext_en <= 48'h0000_0000_0007;
    repeat (8) @(posedge mclk);
    chk_irq(3'h0);
    test_done();
  end
endmodule
`default_nettype wire

//--- testbench/mpgc_pin_env.sv
// board side of the 48 gpio pads: weak pull-ups plus optional board drivers
// assumes active-low pad enables from the gpio block and one pad per bit
`timescale 1ns/10ps
`default_nettype none
module mpgc_pin_env (
  input  wire logic [47:0] pad_out,
  input  wire logic [47:0] pad_oe_n,
  input  wire logic [47:0] ext_en,
  input  wire logic [47:0] ext_val,
  output var  logic [47:0] pad_in
);
  // ==========================================
  // pin level: block driver, else board driver, else pull-up
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      if (pad_oe_n[i] === 1'b0) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i] === 1'b1) begin
        pad_in[i] = ext_val[i];
      end else begin
        pad_in[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
